// ===== core/pal_delay.sv
/*
  on/off delay stage of one alarm channel: the output follows the raw alarm
  only after it has stood for the programmed number of second ticks.
  assumes a one-cycle second tick from the same clock.
*/
`timescale 1ns/1ps
`include "pal_defs.svh"

module pal_delay (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic raw_i,
  input wire logic sec_tick_i,
  input wire logic [`PAL_DLY_W-1:0] on_delay_i,
  input wire logic [`PAL_DLY_W-1:0] off_delay_i,
  output logic alarm_o
);

  logic [`PAL_DLY_W-1:0] sec_cnt;
  logic [`PAL_DLY_W-1:0] limit;

  // delay that applies to the pending change
  assign limit = raw_i ? on_delay_i : off_delay_i;

  // ----------------------------------------------------------------
  // second counter and output
  // ----------------------------------------------------------------
  // counter restarts whenever raw and output agree
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sec_cnt <= '0;
      alarm_o <= 1'b0;
    end else if (raw_i == alarm_o) begin
      sec_cnt <= '0;
    end else if (limit == '0) begin
      alarm_o <= raw_i;
      sec_cnt <= '0;
    end else if (sec_tick_i) begin
      if (sec_cnt + 10'h001 >= limit) begin
        alarm_o <= raw_i;
        sec_cnt <= '0;
      end else begin
        sec_cnt <= sec_cnt + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  a_zero_delay_on: assert property ((on_delay_i == '0) && raw_i && !alarm_o |=> alarm_o)
    else $error("zero on delay did not switch at once");
  a_change_cause: assert property (($rose(alarm_o) |-> $past(raw_i)) and ($fell(alarm_o) |-> !$past(raw_i)))
    else $error("output changed against raw alarm");

endmodule

// ===== core/pal_top.sv
/*
  process alarm evaluator: per-channel alarm type decode, standby hold,
  on/off delays and routing onto the auxiliary outputs, with a register port.
  assumes process values arrive on the core clock; the heater fault pin is asynchronous.
*/
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "pal_defs.svh"

module pal_top #(
  parameter int TICK_CYCLES = `PAL_TICK_CYCLES,
  parameter bit HEATER_VARIANT = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [`PAL_AW-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic signed [`PAL_DW-1:0] process_value_i,
  input wire logic signed [`PAL_DW-1:0] set_point_i,
  input wire logic signed [`PAL_DW-1:0] manipulated_variable_i,
  input wire logic signed [`PAL_DW-1:0] manipulated_variable_cool_i,
  input wire logic loop_break_trip_i,
  input wire logic pv_rate_exceed_i,
  input wire logic heater_fault_trip_i,
  output logic [`PAL_NUM_CH-1:0] aux_o
);

  localparam int NCH = `PAL_NUM_CH;

  logic heat_cool;
  logic [`PAL_DW-1:0] hyst;
  logic [2*`PAL_ASSIGN_W-1:0] assign_sel;
  logic [4:0] ch_type [NCH];
  logic signed [`PAL_DW-1:0] ch_trip [NCH];
  logic signed [`PAL_DW-1:0] ch_upper [NCH];
  logic signed [`PAL_DW-1:0] ch_lower [NCH];
  logic [`PAL_DLY_W-1:0] ch_on_dly [NCH];
  logic [`PAL_DLY_W-1:0] ch_off_dly [NCH];
  logic [NCH-1:0] type_wr;
  logic [NCH-1:0] raw;
  logic [NCH-1:0] hold;
  logic [NCH-1:0] alarm;
  logic [2:0] hf_sync;
  logic heater_fault;
  logic type1_hidden;
  logic [26:0] tick_cnt;
  logic sec_tick;
  logic [31:0] next_rdata;

  // in the heater variant only, type setting of channel 1 is hidden while output 1 is not on alarm 1
  assign type1_hidden = HEATER_VARIANT && (assign_sel[1:0] != pal_pkg::SRC_ALARM1);

  // ----------------------------------------------------------------
  // heater fault pin synchroniser
  // ----------------------------------------------------------------
  // change accepted once the second and third stages agree
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hf_sync <= 3'h0;
      heater_fault <= 1'b0;
    end else begin
      hf_sync <= {hf_sync[1:0], heater_fault_trip_i};
      if (hf_sync[1] == hf_sync[2]) begin
        heater_fault <= hf_sync[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // one-second tick
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt <= '0;
      sec_tick <= 1'b0;
    end else if (tick_cnt == 27'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      sec_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 27'h0000001;
      sec_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // type write decode and acceptance
  // ----------------------------------------------------------------
  // out-of-range codes, loop break off channel 1 and hidden writes are dropped
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      type_wr[c] = wr_i && (addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_TYPE))
        && (wdata_i[31:5] == '0) && (wdata_i[4:0] <= `PAL_TYPE_MAX)
        && !(c != 0 && wdata_i[4:0] == pal_pkg::AT_LOOP_BREAK)
        && !(c == 0 && type1_hidden);
    end
  end

  // ----------------------------------------------------------------
  // global configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      heat_cool <= 1'b0;
      hyst <= '0;
      assign_sel <= HEATER_VARIANT ? `PAL_ASSIGN_RESET_HEATER : `PAL_ASSIGN_RESET_PLAIN;
    end else if (wr_i) begin
      if (addr_i == `PAL_OFF_CTRL) begin
        heat_cool <= wdata_i[`PAL_CTRL_HEAT_COOL];
      end
      if (addr_i == `PAL_OFF_HYST) begin
        hyst <= wdata_i[`PAL_DW-1:0];
      end
      if (addr_i == `PAL_OFF_ASSIGN) begin
        assign_sel <= wdata_i[2*`PAL_ASSIGN_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel setting registers
  // ----------------------------------------------------------------
  // delays above the top of range are clipped to it
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int c = 0; c < NCH; c++) begin
        ch_type[c] <= `PAL_TYPE_RESET;
        ch_trip[c] <= '0;
        ch_upper[c] <= '0;
        ch_lower[c] <= '0;
        ch_on_dly[c] <= '0;
        ch_off_dly[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (type_wr[c]) begin
          ch_type[c] <= wdata_i[4:0];
        end
        if (wr_i && addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_TRIP)) begin
          ch_trip[c] <= wdata_i[`PAL_DW-1:0];
        end
        if (wr_i && addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_UPPER)) begin
          ch_upper[c] <= wdata_i[`PAL_DW-1:0];
        end
        if (wr_i && addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_LOWER)) begin
          ch_lower[c] <= wdata_i[`PAL_DW-1:0];
        end
        if (wr_i && addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_ON_DLY)) begin
          ch_on_dly[c] <= (wdata_i > 32'(`PAL_DELAY_MAX_S)) ? `PAL_DELAY_MAX_S : wdata_i[`PAL_DLY_W-1:0];
        end
        if (wr_i && addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_OFF_DLY)) begin
          ch_off_dly[c] <= (wdata_i > 32'(`PAL_DELAY_MAX_S)) ? `PAL_DELAY_MAX_S : wdata_i[`PAL_DLY_W-1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel evaluation
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : gen_ch
    logic signed [`PAL_DW+1:0] pv;
    logic signed [`PAL_DW+1:0] sp;
    logic signed [`PAL_DW+1:0] x;
    logic signed [`PAL_DW+1:0] up_lim;
    logic signed [`PAL_DW+1:0] lo_lim;
    logic signed [`PAL_DW+1:0] mv_up;
    logic signed [`PAL_DW+1:0] mv_lo;
    logic in_band;
    logic overlap;
    logic standby;
    logic cond;

    assign pv = 18'(process_value_i);
    assign sp = 18'(set_point_i);
    assign x = 18'(ch_trip[g]);
    assign up_lim = sp + 18'(ch_upper[g]);
    assign lo_lim = sp + 18'(ch_lower[g]);
    assign in_band = (pv >= lo_lim) && (pv <= up_lim);
    // upper alarm watches heating, lower alarm watches cooling when heat_cool is set, else heating
    assign mv_up = 18'(manipulated_variable_i);
    assign mv_lo = heat_cool ? 18'(manipulated_variable_cool_i) : 18'(manipulated_variable_i);
    // hysteresis regions of both limits touch or cross
    assign overlap = (18'(ch_upper[g]) - 18'(ch_lower[g])) <= $signed(18'(hyst) + 18'(hyst));
    assign standby = (ch_type[g] == pal_pkg::AT_BAND_OUT_SB) || (ch_type[g] == pal_pkg::AT_DEV_UP_SB)
      || (ch_type[g] == pal_pkg::AT_DEV_LO_SB) || (ch_type[g] == pal_pkg::AT_ABS_UP_SB)
      || (ch_type[g] == pal_pkg::AT_ABS_LO_SB);

    // base condition of the selected type, before standby
    always_comb begin
      cond = 1'b0;
      unique case (ch_type[g])
        pal_pkg::AT_OFF: cond = 1'b0;
        pal_pkg::AT_BAND_OUT: cond = !in_band;
        pal_pkg::AT_DEV_UP: cond = pv >= sp + x;
        pal_pkg::AT_DEV_LO: cond = pv <= sp - x;
        pal_pkg::AT_BAND_IN: cond = in_band;
        pal_pkg::AT_BAND_OUT_SB: cond = !in_band && !overlap;
        pal_pkg::AT_DEV_UP_SB: cond = pv >= sp + x;
        pal_pkg::AT_DEV_LO_SB: cond = pv <= sp - x;
        pal_pkg::AT_ABS_UP: cond = pv > x;
        pal_pkg::AT_ABS_LO: cond = pv < x;
        pal_pkg::AT_ABS_UP_SB: cond = pv > x;
        pal_pkg::AT_ABS_LO_SB: cond = pv < x;
        pal_pkg::AT_LOOP_BREAK: cond = (g == 0) && loop_break_trip_i;
        pal_pkg::AT_RATE: cond = pv_rate_exceed_i;
        pal_pkg::AT_SP_UP: cond = sp > x;
        pal_pkg::AT_SP_LO: cond = sp < x;
        pal_pkg::AT_MV_UP: cond = (x < 0) || (mv_up > x);
        pal_pkg::AT_MV_LO: cond = (x < 0) || (mv_lo < x);
        default: cond = 1'b0;
      endcase
    end

    // standby hold armed at start-up and on a type change
    always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
        hold[g] <= 1'b1;
      end else if (type_wr[g]) begin
        hold[g] <= 1'b1;
      end else if (!cond) begin
        hold[g] <= 1'b0;
      end
    end

    assign raw[g] = cond && !(standby && hold[g]);

    pal_delay u_delay (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .raw_i(raw[g]),
      .sec_tick_i(sec_tick),
      .on_delay_i(ch_on_dly[g]),
      .off_delay_i(ch_off_dly[g]),
      .alarm_o(alarm[g])
    );

    a_type_off: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (ch_type[g] == pal_pkg::AT_OFF) |-> !raw[g])
      else $error("disabled channel raised its alarm");
    a_mv_negative: assert property (@(posedge core_clk_i) disable iff (reset_i)
      ((ch_type[g] == pal_pkg::AT_MV_UP) || (ch_type[g] == pal_pkg::AT_MV_LO)) && (ch_trip[g][`PAL_DW-1]) |-> raw[g])
      else $error("negative trip on manipulated variable alarm not held on");
    a_band_overlap: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (ch_type[g] == pal_pkg::AT_BAND_OUT_SB) && (ch_upper[g] <= ch_lower[g]) |-> !raw[g])
      else $error("band standby alarm on with overlapping limits");
    a_standby_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
      type_wr[g] && (wdata_i[4:0] == pal_pkg::AT_DEV_UP_SB) ##1 (ch_type[g] == pal_pkg::AT_DEV_UP_SB) |-> !raw[g])
      else $error("standby did not suppress right after type change");
    a_bad_type: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !type_wr[g] |=> $stable(ch_type[g]))
      else $error("type changed without an accepted write");
  end

  // ----------------------------------------------------------------
  // auxiliary output routing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      aux_o <= '0;
    end else begin
      for (int k = 0; k < NCH; k++) begin
        unique case (assign_sel[k*`PAL_ASSIGN_W +: `PAL_ASSIGN_W])
          pal_pkg::SRC_NONE: aux_o[k] <= 1'b0;
          pal_pkg::SRC_ALARM1: aux_o[k] <= alarm[0];
          pal_pkg::SRC_ALARM2: aux_o[k] <= alarm[1];
          pal_pkg::SRC_HEATER: aux_o[k] <= heater_fault;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h00000000;
    if (addr_i == `PAL_OFF_CTRL) begin
      next_rdata = 32'(heat_cool);
    end else if (addr_i == `PAL_OFF_HYST) begin
      next_rdata = 32'(hyst);
    end else if (addr_i == `PAL_OFF_ASSIGN) begin
      next_rdata = 32'(assign_sel);
    end else if (addr_i == `PAL_OFF_STATUS) begin
      next_rdata = 32'({heater_fault, hold, raw, alarm});
    end
    for (int c = 0; c < NCH; c++) begin
      if (addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_TYPE)) begin
        next_rdata = (c == 0 && type1_hidden) ? 32'h00000000 : 32'(ch_type[c]);
      end
      if (addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_TRIP)) begin
        next_rdata = 32'(ch_trip[c]);
      end
      if (addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_UPPER)) begin
        next_rdata = 32'(ch_upper[c]);
      end
      if (addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_LOWER)) begin
        next_rdata = 32'(ch_lower[c]);
      end
      if (addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_ON_DLY)) begin
        next_rdata = 32'(ch_on_dly[c]);
      end
      if (addr_i == 8'(`PAL_CH_BASE + c * `PAL_CH_STRIDE + `PAL_CH_OFF_DLY)) begin
        next_rdata = 32'(ch_off_dly[c]);
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= rd_i ? next_rdata : 32'h00000000;
    end
  end

  a_aux_route: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (assign_sel[1:0] == pal_pkg::SRC_ALARM2) |=> (aux_o[0] == $past(alarm[1])))
    else $error("aux output 0 did not follow alarm 2");
  a_type1_hidden: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rd_i && type1_hidden && (addr_i == `PAL_CH_BASE) |=> (rdata_o == 32'h00000000))
    else $error("hidden channel 1 type was readable");
  a_lba_ch2: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_i && (addr_i == 8'h40) && (wdata_i == 32'h0000000C) |-> !type_wr[1])
    else $error("loop break accepted on channel 2");

endmodule

// ===== inc/pal_defs.svh
/*
  constants for the process alarm evaluator: register offsets, field positions,
  reset values, type codes and timing counts.
  assumes a 100 MHz core clock and a word-aligned byte address on the register port.
*/
`ifndef PAL_DEFS_SVH
`define PAL_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PAL_NUM_CH 2
`define PAL_DW 16
`define PAL_AW 8
`define PAL_DLY_W 10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PAL_CLK_HZ 100000000
`define PAL_DELAY_UNIT_S 1
`define PAL_TICK_CYCLES (`PAL_CLK_HZ * `PAL_DELAY_UNIT_S)
`define PAL_DELAY_MAX_S 10'h3E7

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PAL_OFF_CTRL 8'h00
`define PAL_OFF_HYST 8'h04
`define PAL_OFF_ASSIGN 8'h08
`define PAL_OFF_STATUS 8'h0C
`define PAL_CH_BASE 8'h20
`define PAL_CH_STRIDE 8'h20
`define PAL_CH_TYPE 8'h00
`define PAL_CH_TRIP 8'h04
`define PAL_CH_UPPER 8'h08
`define PAL_CH_LOWER 8'h0C
`define PAL_CH_ON_DLY 8'h10
`define PAL_CH_OFF_DLY 8'h14

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PAL_CTRL_HEAT_COOL 0
`define PAL_TYPE_MAX 5'h12
`define PAL_TYPE_RESET 5'h02
`define PAL_ASSIGN_W 2
`define PAL_ASSIGN_RESET_PLAIN 4'h9
`define PAL_ASSIGN_RESET_HEATER 4'hB
`define PAL_STATUS_OUT 0
`define PAL_STATUS_RAW 2
`define PAL_STATUS_STBY 4
`define PAL_STATUS_HFAULT 6

`endif

// ===== inc/pal_pkg.sv
/*
  types of the process alarm evaluator: alarm type codes and output sources.
  assumes pal_defs.svh sits on the include path.
*/
`include "pal_defs.svh"

package pal_pkg;

  // ----------------------------------------------------------------
  // alarm type codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    AT_OFF = 5'h00,
    AT_BAND_OUT = 5'h01,
    AT_DEV_UP = 5'h02,
    AT_DEV_LO = 5'h03,
    AT_BAND_IN = 5'h04,
    AT_BAND_OUT_SB = 5'h05,
    AT_DEV_UP_SB = 5'h06,
    AT_DEV_LO_SB = 5'h07,
    AT_ABS_UP = 5'h08,
    AT_ABS_LO = 5'h09,
    AT_ABS_UP_SB = 5'h0A,
    AT_ABS_LO_SB = 5'h0B,
    AT_LOOP_BREAK = 5'h0C,
    AT_RATE = 5'h0D,
    AT_SP_UP = 5'h0E,
    AT_SP_LO = 5'h0F,
    AT_MV_UP = 5'h10,
    AT_MV_LO = 5'h11,
    AT_SPARE = 5'h12
  } pal_alarm_type;

  // ----------------------------------------------------------------
  // auxiliary output sources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_ALARM1 = 2'h1,
    SRC_ALARM2 = 2'h2,
    SRC_HEATER = 2'h3
  } pal_src_type;

endpackage

// ===== tb/pal_aux_stage.sv
/*
  model of the auxiliary output stages: one relay per output, pulled in one
  clock after the alarm output rises and dropped one clock after it falls.
  assumes the alarm outputs are registered on the same core clock.
*/
`timescale 1ns/1ps

module pal_aux_stage (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] aux_i,
  output logic [1:0] relay_o
);
  // ----------------------------------------------------------------
  // relay coils
  // ----------------------------------------------------------------
  // coils follow the drive one clock late, released while in reset
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      relay_o <= 2'h0;
    end else begin
      relay_o <= aux_i;
    end
  end
endmodule

// ===== tb/process_alarm_evaluator_tb_top.sv
/*
  self-checking bench of the alarm evaluator: table of alarm cases, then
  reset, refused writes, routing, standby, overlap, delay and heater cases.
  assumes pal_top with a 10-cycle second tick and a heater-variant twin.
*/
`timescale 1ns/1ps

module process_alarm_evaluator_tb_top;
  typedef struct packed {
    logic [4:0] t;
    logic [15:0] x, h, l, pval, spt, mvar;
    logic lb, rt, e;
  } pal_row_type;
  logic core_clk_i = 1'h0, reset_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, lb = 1'h0, rt = 1'h0, hf = 1'h0;
  logic [7:0] addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0, rd0, rd1, rdata_a, rdata_b;
  logic signed [15:0] proc_val = 16'h0, set_pt = 16'h0, man_var = 16'h0, man_cool = 16'h0;
  logic [1:0] aux_a, aux_b, relay;
  int err_total = 0;
  int checks = 0;
  pal_row_type rows [22] = '{
    '{5'h0, 16'h0, 16'h0, 16'h0, 16'h64, 16'h0, 16'h0, 1'h0, 1'h0, 1'h0},
    '{5'h1, 16'h0, 16'hA, 16'hFFF6, 16'hB, 16'h0, 16'h0, 1'h0, 1'h0, 1'h1},
    '{5'h1, 16'h0, 16'hA, 16'hFFF6, 16'h0, 16'h0, 16'h0, 1'h0, 1'h0, 1'h0},
    '{5'h2, 16'hA, 16'h0, 16'h0, 16'hA, 16'h0, 16'h0, 1'h0, 1'h0, 1'h1},
    '{5'h2, 16'hA, 16'h0, 16'h0, 16'h9, 16'h0, 16'h0, 1'h0, 1'h0, 1'h0},
    '{5'h3, 16'hA, 16'h0, 16'h0, 16'hFFF6, 16'h0, 16'h0, 1'h0, 1'h0, 1'h1},
    '{5'h3, 16'hA, 16'h0, 16'h0, 16'hFFF7, 16'h0, 16'h0, 1'h0, 1'h0, 1'h0},
    '{5'h4, 16'h0, 16'hA, 16'hFFF6, 16'h0, 16'h0, 16'h0, 1'h0, 1'h0, 1'h1},
    '{5'h4, 16'h0, 16'hA, 16'hFFF6, 16'h14, 16'h0, 16'h0, 1'h0, 1'h0, 1'h0},
    '{5'h8, 16'h5, 16'h0, 16'h0, 16'h6, 16'h0, 16'h0, 1'h0, 1'h0, 1'h1},
    '{5'h9, 16'h5, 16'h0, 16'h0, 16'h5, 16'h0, 16'h0, 1'h0, 1'h0, 1'h0},
    '{5'hE, 16'h5, 16'h0, 16'h0, 16'h0, 16'h6, 16'h0, 1'h0, 1'h0, 1'h1},
    '{5'hF, 16'h5, 16'h0, 16'h0, 16'h0, 16'h5, 16'h0, 1'h0, 1'h0, 1'h0},
    '{5'h10, 16'h5, 16'h0, 16'h0, 16'h0, 16'h0, 16'h6, 1'h0, 1'h0, 1'h1},
    '{5'h11, 16'hFFFF, 16'h0, 16'h0, 16'h0, 16'h0, 16'h64, 1'h0, 1'h0, 1'h1},
    '{5'hC, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'h1, 1'h0, 1'h1},
    '{5'hD, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'h0, 1'h1, 1'h1},
    '{5'h7, 16'hA, 16'h0, 16'h0, 16'hFFEC, 16'h0, 16'h0, 1'h0, 1'h0, 1'h0},
    '{5'hB, 16'h5, 16'h0, 16'h0, 16'h4, 16'h0, 16'h0, 1'h0, 1'h0, 1'h0},
    '{5'h12, 16'h0, 16'h0, 16'h0, 16'h64, 16'h0, 16'h0, 1'h0, 1'h0, 1'h0},
    '{5'hA, 16'h5, 16'h0, 16'h0, 16'h6, 16'h0, 16'h0, 1'h0, 1'h0, 1'h0},
    '{5'h6, 16'hA, 16'h0, 16'h0, 16'h14, 16'h0, 16'h0, 1'h0, 1'h0, 1'h0}
  };

  // ----------------------------------------------------------------
  // design, heater twin and output stages
  // ----------------------------------------------------------------
  pal_top #(.TICK_CYCLES(10), .HEATER_VARIANT(1'b0)) i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_a), .process_value_i(proc_val),
    .set_point_i(set_pt), .manipulated_variable_i(man_var), .manipulated_variable_cool_i(man_cool),
    .loop_break_trip_i(lb), .pv_rate_exceed_i(rt), .heater_fault_trip_i(hf), .aux_o(aux_a));
  pal_top #(.TICK_CYCLES(10), .HEATER_VARIANT(1'b1)) i_dut_heat (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_b), .process_value_i(proc_val),
    .set_point_i(set_pt), .manipulated_variable_i(man_var), .manipulated_variable_cool_i(man_cool),
    .loop_break_trip_i(lb), .pv_rate_exceed_i(rt), .heater_fault_trip_i(hf), .aux_o(aux_b));
  pal_aux_stage i_stage (.core_clk_i(core_clk_i), .reset_i(reset_i), .aux_i(aux_a), .relay_o(relay));

  // ----------------------------------------------------------------
  // bus cycles, compares and verdict
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'h0;
    #1;
    rd0 = rdata_a;
    rd1 = rdata_b;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_aux(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: outputs %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------------------------------
  // 100 MHz core clock
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  // cuts a hang short well past the expected run
  initial begin
    #200000;
    err_total++;
    tally_and_finish;
  end
  // reset, table of cases, then the awkward cases
  initial begin
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'h0;
    foreach (rows[i]) begin
      @(posedge core_clk_i);
      proc_val <= rows[i].pval;
      set_pt <= rows[i].spt;
      man_var <= rows[i].mvar;
      lb <= rows[i].lb;
      rt <= rows[i].rt;
      wr(8'h24, {16'h0, rows[i].x});
      wr(8'h28, {16'h0, rows[i].h});
      wr(8'h2C, {16'h0, rows[i].l});
      wr(8'h20, {27'h0, rows[i].t});
      settle(4);
      cmp_aux(aux_a[0], rows[i].e);
    end
    // standby released once the value has been clear
    @(posedge core_clk_i);
    proc_val <= 16'h0;
    settle(4);
    @(posedge core_clk_i);
    proc_val <= 16'h14;
    settle(4);
    cmp_aux(aux_a[0], 1'h1);
    wr(8'h08, 32'h5);
    settle(4);
    cmp_aux(aux_a, 2'h3);
    wr(8'h00, 32'h1);
    man_var <= 16'h64;
    wr(8'h24, 32'h5);
    wr(8'h20, 32'h11);
    settle(4);
    cmp_aux(aux_a, 2'h3);
    wr(8'h04, 32'hA);
    wr(8'h28, 32'hA);
    wr(8'h2C, 32'hFFF6);
    proc_val <= 16'h0;
    wr(8'h20, 32'h5);
    settle(4);
    @(posedge core_clk_i);
    proc_val <= 16'h64;
    settle(4);
    cmp_aux(aux_a, 2'h0);
    wr(8'h04, 32'h0);
    wr(8'h30, 32'h3E8);
    rd(8'h30);
    cmp_reg(rd0, 32'h3E7);
    wr(8'h30, 32'h3);
    proc_val <= 16'h0;
    settle(6);
    @(posedge core_clk_i);
    proc_val <= 16'h64;
    settle(15);
    cmp_aux(aux_a, 2'h0);
    settle(25);
    cmp_aux(aux_a, 2'h3);
    cmp_aux(relay, 2'h3);
    // crossed routing, then inverted band with standby
    wr(8'h40, 32'h0);
    wr(8'h08, 32'h6);
    settle(4);
    cmp_aux(aux_a, 2'h2);
    wr(8'h28, 32'hFFF6);
    wr(8'h2C, 32'hA);
    settle(4);
    cmp_aux(aux_a, 2'h0);
    // mid-run reset, then reset values, refused writes and heater routing
    @(posedge core_clk_i);
    reset_i <= 1'h1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'h0;
    rd(8'h20);
    cmp_reg(rd0, 32'h2);
    cmp_reg(rd1, 32'h0);
    rd(8'h08);
    cmp_reg(rd0, 32'h9);
    cmp_reg(rd1, 32'hB);
    rd(8'hFC);
    cmp_reg(rd0, 32'h0);
    @(posedge core_clk_i);
    hf <= 1'h1;
    settle(8);
    cmp_aux(aux_b, 2'h3);
    wr(8'h08, 32'h9);
    wr(8'h20, 32'h1);
    rd(8'h20);
    cmp_reg(rd1, 32'h1);
    wr(8'h40, 32'hC);
    wr(8'h20, 32'h13);
    rd(8'h40);
    cmp_reg(rd0, 32'h2);
    rd(8'h20);
    cmp_reg(rd0, 32'h1);
    tally_and_finish;
  end
endmodule
